/* File: rtl/ais_cfg.svh */
// timing counts and field positions for the adapter init sequencer
`ifndef AIS_CFG_SVH
`define AIS_CFG_SVH
`define AIS_CLK_NS          50
`define AIS_RESET_HOLD_NS   2000
`define AIS_RESET_HOLD_CYC  ((`AIS_RESET_HOLD_NS + `AIS_CLK_NS - 1) / `AIS_CLK_NS)
`define AIS_SYSRST_NS       200000
`define AIS_SYSRST_CYC      ((`AIS_SYSRST_NS + `AIS_CLK_NS - 1) / `AIS_CLK_NS)
`define AIS_NODE_RESET_BIT  30
`define AIS_LOCAL_INIT_BIT  22
`define AIS_CNT_W           16
`define AIS_PIN_IDLE        2'h3
`endif

/* File: rtl/ais_pkg.sv */
// types shared by the adapter init sequencer
package ais_pkg;
  typedef enum logic [2:0] {
    AIS_IDLE,
    AIS_HOLD,
    AIS_SELFTEST,
    AIS_RUN
  } ais_state_e;

  typedef struct packed {
    logic reset_all;
    logic reset_local;
  } ais_reset_s;
endpackage

/* File: rtl/ais_sync.sv */
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
module ais_sync #(
  parameter int WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      stage1   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

/* File: rtl/ais_top.sv */
// adapter init sequencer: merges reset sources, drives self-test fail and vme reset
`timescale 1ns/10ps
`include "ais_cfg.svh"
module ais_top #(
  parameter int HOLD_CYC   = `AIS_RESET_HOLD_CYC,
  parameter int SYSRST_CYC = `AIS_SYSRST_CYC
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        system_ac_low_n,
  input  wire logic        system_dc_low_n,
  input  wire logic        bus_err_wr,
  input  wire logic [31:0] bus_err_wdata,
  input  wire logic        dev_cfg_wr,
  input  wire logic [31:0] dev_cfg_wdata,
  input  wire logic        selftest_done,
  input  wire logic        selftest_pass,
  output logic             adapter_reset,
  output logic             local_sm_reset,
  output logic             selftest_start,
  output logic             self_test_fail_n,
  output logic             self_test_fail_oe_n,
  output logic             vme_sysreset_n,
  output logic             vme_sysreset_oe_n,
  output logic             node_reset_pending,
  output logic             local_init_pending
);
  // ==========================================================
  // pin synchronisers
  logic [1:0] pins_sync;
  logic       ac_low;
  logic       dc_low;
  logic       ac_seen;

  // idle-high reset value, so no false power sequence follows rstn
  ais_sync #(
    .WIDTH     (2),
    .RESET_VAL (`AIS_PIN_IDLE)
  ) u_sync (
    .clock    (clock),
    .rstn     (rstn),
    .async_in ({system_ac_low_n, system_dc_low_n}),
    .sync_out (pins_sync)
  );

  assign ac_low = ~pins_sync[1];
  assign dc_low = ~pins_sync[0];

  // ==========================================================
  // request capture
  logic node_req;
  logic local_req;
  logic power_req;
  ais_pkg::ais_reset_s rst_cmd;
  ais_pkg::ais_state_e state;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      ac_seen <= 1'b0;
    else if (!ac_low && !dc_low)
      ac_seen <= 1'b0;
    else if (ac_low)
      ac_seen <= 1'b1;
  end

  // power sequence, emulated or real, looks the same here
  assign power_req = dc_low & ac_seen;

  // node reset request; set wins over clear
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      node_req <= 1'b0;
    else if (bus_err_wr && bus_err_wdata[`AIS_NODE_RESET_BIT])
      node_req <= 1'b1;
    else if (state == ais_pkg::AIS_HOLD && !rst_cmd.reset_local)
      node_req <= 1'b0;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      local_req <= 1'b0;
    else if (dev_cfg_wr && dev_cfg_wdata[`AIS_LOCAL_INIT_BIT])
      local_req <= 1'b1;
    else if (local_sm_reset)
      local_req <= 1'b0;
  end

  assign node_reset_pending = node_req;
  assign local_init_pending = local_req;

  // ==========================================================
  // sequencer
  logic [`AIS_CNT_W-1:0] hold_cnt;
  logic [`AIS_CNT_W-1:0] sysrst_cnt;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state       <= ais_pkg::AIS_HOLD;
      rst_cmd     <= '{reset_all: 1'b1, reset_local: 1'b0};
      hold_cnt    <= '0;
    end
    else if (power_req || (node_req && state != ais_pkg::AIS_HOLD))
    begin
      state       <= ais_pkg::AIS_HOLD;
      rst_cmd     <= '{reset_all: 1'b1, reset_local: 1'b0};
      hold_cnt    <= '0;
    end
    else
    begin
      case (state)
        ais_pkg::AIS_HOLD:
        begin
          // power pins still low keep the hold going
          if (dc_low || ac_low)
            hold_cnt <= '0;
          else if (hold_cnt == HOLD_CYC[`AIS_CNT_W-1:0] - 1'b1)
          begin
            state   <= rst_cmd.reset_all ? ais_pkg::AIS_SELFTEST : ais_pkg::AIS_RUN;
            rst_cmd <= '{reset_all: 1'b0, reset_local: 1'b0};
          end
          else
            hold_cnt <= hold_cnt + 1'b1;
        end
        ais_pkg::AIS_SELFTEST:
        begin
          // failed self-test leaves the fail line asserted
          if (selftest_done && selftest_pass)
            state <= ais_pkg::AIS_RUN;
        end
        ais_pkg::AIS_RUN:
        begin
          if (local_req)
          begin
            state    <= ais_pkg::AIS_HOLD;
            rst_cmd  <= '{reset_all: 1'b0, reset_local: 1'b1};
            hold_cnt <= '0;
          end
        end
        default:
          state <= ais_pkg::AIS_HOLD;
      endcase
    end
  end

  // full reset to all logic and registers; local state machine reset on full or local init
  assign adapter_reset  = (state == ais_pkg::AIS_HOLD) && rst_cmd.reset_all;
  assign local_sm_reset = (state == ais_pkg::AIS_HOLD) && (rst_cmd.reset_all | rst_cmd.reset_local);

  // ==========================================================
  // outputs
  logic selftest_arm;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      selftest_arm <= 1'b0;
    else
      selftest_arm <= adapter_reset;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      selftest_start <= 1'b0;
    else
      selftest_start <= selftest_arm & ~adapter_reset;
  end

  // fail line held until self-test passes
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      self_test_fail_n    <= 1'b0;
      self_test_fail_oe_n <= 1'b0;
    end
    else
    begin
      self_test_fail_n    <= 1'b0;
      self_test_fail_oe_n <= ~(adapter_reset || state == ais_pkg::AIS_SELFTEST);
    end
  end

  // vme reset pulse after each full init
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      sysrst_cnt <= SYSRST_CYC[`AIS_CNT_W-1:0];
    else if (adapter_reset)
      sysrst_cnt <= SYSRST_CYC[`AIS_CNT_W-1:0];
    else if (sysrst_cnt != '0)
      sysrst_cnt <= sysrst_cnt - 1'b1;
  end

  // open-drain: only ever pulls low
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      vme_sysreset_n    <= 1'b0;
      vme_sysreset_oe_n <= 1'b0;
    end
    else
    begin
      vme_sysreset_n    <= 1'b0;
      vme_sysreset_oe_n <= (sysrst_cnt == '0) && !adapter_reset;
    end
  end
endmodule

/* File: sim/ais_properties.sv */
// port assertions for the adapter init sequencer
`timescale 1ns/10ps
module ais_properties #(
  parameter int HOLD_CYC   = 4,
  parameter int SYSRST_CYC = 8
) (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        bus_err_wr,
  input wire logic [31:0] bus_err_wdata,
  input wire logic        dev_cfg_wr,
  input wire logic [31:0] dev_cfg_wdata,
  input wire logic        adapter_reset,
  input wire logic        local_sm_reset,
  input wire logic        selftest_start,
  input wire logic        self_test_fail_n,
  input wire logic        self_test_fail_oe_n,
  input wire logic        vme_sysreset_n,
  input wire logic        vme_sysreset_oe_n,
  input wire logic        node_reset_pending,
  input wire logic        local_init_pending
);
  // =====
  // sequences and properties
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  sequence node_req;
    bus_err_wr && bus_err_wdata[30];
  endsequence
  sequence local_only;
    $rose(local_sm_reset) && !adapter_reset;
  endsequence
  node_req_a: assert property (node_req |=> node_reset_pending ##1 adapter_reset)
    else $error("node reset not applied");
  node_clear_a: assert property ($rose(adapter_reset) |=> !node_reset_pending)
    else $error("node request not cleared");
  full_local_a: assert property (adapter_reset |-> local_sm_reset)
    else $error("local logic left running");
  stf_hold_a: assert property (adapter_reset |=> !self_test_fail_oe_n)
    else $error("self test fail released in reset");
  stf_start_a: assert property ($fell(adapter_reset) |-> ##[0:1] selftest_start)
    else $error("self test not started");
  pin_drive_a: assert property (!self_test_fail_n && !vme_sysreset_n)
    else $error("open drain pin driven high");
  vme_hold_a: assert property ($fell(adapter_reset) |-> !vme_sysreset_oe_n [*7])
    else $error("vme reset too short");
  cfg_req_a: assert property (dev_cfg_wr && dev_cfg_wdata[22] |=> local_init_pending)
    else $error("local init not taken");
  local_only_a: assert property (local_only |-> self_test_fail_oe_n && !selftest_start)
    else $error("local init touched self test");
  local_hold_a: assert property (local_only |-> local_sm_reset [*4] ##1 !local_sm_reset)
    else $error("local reset length wrong");
  local_clear_a: assert property (local_only |=> !local_init_pending)
    else $error("local request not cleared");
endmodule

/* File: sim/ais_selftest_model.sv */
// self-test engine model: answers each start after a chosen delay
`timescale 1ns/10ps
module ais_selftest_model (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       start,
  input  wire logic       fail_mode,
  input  wire logic [3:0] delay,
  output logic            done,
  output logic            pass
);
  logic [4:0] cnt;
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      cnt  <= 5'h00;
      done <= 1'b0;
      pass <= 1'b0;
    end
    else
    begin
      done <= cnt == 5'h01;
      // result is only meaningful with done, so it toggles otherwise
      pass <= (cnt == 5'h01) ? !fail_mode : !pass;
      cnt  <= start ? {1'b0, delay} + 5'h02 : (cnt != 5'h00) ? cnt - 5'h01 : cnt;
    end
endmodule

/* File: sim/tb_top.sv */
// self-checking bench for the adapter init sequencer
`timescale 1ns/10ps
module tb_top;
  logic        clock, rstn, ac_n, dc_n, be_wr, cf_wr, st_done, st_pass, fail_mode;
  logic [31:0] be_d, cf_d, seed;
  logic [3:0]  st_dly;
  logic        a_rst, l_rst, st_go, stf_n, stf_oe_n, vme_n, vme_oe_n, node_p, loc_p;
  int          n_errors, tests_run;
  ais_top #(.HOLD_CYC(4), .SYSRST_CYC(8)) dut (.clock(clock), .rstn(rstn),
    .system_ac_low_n(ac_n), .system_dc_low_n(dc_n), .bus_err_wr(be_wr), .bus_err_wdata(be_d),
    .dev_cfg_wr(cf_wr), .dev_cfg_wdata(cf_d), .selftest_done(st_done), .selftest_pass(st_pass),
    .adapter_reset(a_rst), .local_sm_reset(l_rst), .selftest_start(st_go),
    .self_test_fail_n(stf_n), .self_test_fail_oe_n(stf_oe_n), .vme_sysreset_n(vme_n),
    .vme_sysreset_oe_n(vme_oe_n), .node_reset_pending(node_p), .local_init_pending(loc_p));
  ais_selftest_model st (.clock(clock), .rstn(rstn), .start(st_go), .fail_mode(fail_mode),
    .delay(st_dly), .done(st_done), .pass(st_pass));
  // =====
  // helpers
  function logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function logic want(input logic [31:0] d, input logic err);
    return err ? d[30] : d[22];
  endfunction
  task chk(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task settle(input int n);
    int i;
    i = 0;
    while (a_rst !== 1'b0 && i < 300)
    begin
      @(negedge clock);
      i++;
    end
    chk(a_rst, 1'b0);
    repeat (n) @(negedge clock);
  endtask
  task poke(input logic err, input logic [31:0] d);
    be_wr = err;
    cf_wr = !err;
    be_d  = d;
    cf_d  = d;
    @(negedge clock);
    be_wr = 1'b0;
    cf_wr = 1'b0;
    chk(err ? node_p : loc_p, want(d, err));
    @(negedge clock);
    chk(a_rst, err & d[30]);
    chk(l_rst, want(d, err));
    settle(20);
    chk(stf_oe_n, 1'b1);
    chk(vme_oe_n, 1'b1);
  endtask
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial
  begin
    repeat (6000) @(posedge clock);
    n_errors++;
    final_report();
  end
  // =====
  // scenarios
  initial
  begin
    {rstn, be_wr, cf_wr, be_d, cf_d} = '0;
    {ac_n, dc_n, fail_mode} = 3'h7;
    seed = 32'h83b9;
    st_dly = 4'h3;
    repeat (16) @(negedge clock);
    chk(a_rst, 1'b1);
    chk(vme_oe_n, 1'b0);
    rstn = 1'b1;
    settle(25);
    chk(stf_oe_n, 1'b0);
    chk(vme_oe_n, 1'b1);
    fail_mode = 1'b0;
    poke(1'b1, 32'h4000_0000);
    poke(1'b0, 32'h0040_0000);
    poke(1'b1, 32'hbfff_ffff);
    for (int k = 0; k < 10; k++)
    begin
      seed = xs(seed);
      st_dly = {1'b0, seed[6:4]};
      poke(seed[0], seed);
    end
    dc_n = 1'b0;
    repeat (6) @(negedge clock);
    chk(a_rst, 1'b0);
    dc_n = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      ac_n = 1'b0;
      repeat (4) @(negedge clock);
      dc_n = 1'b0;
      repeat (4) @(negedge clock);
      chk(a_rst, 1'b1);
      chk(stf_oe_n, 1'b0);
      chk(vme_oe_n, 1'b0);
      {ac_n, dc_n} = 2'h3;
      settle(20);
      chk(stf_oe_n, 1'b1);
      chk(vme_oe_n, 1'b1);
    end
    final_report();
  end
endmodule
bind ais_top ais_properties #(.HOLD_CYC(HOLD_CYC), .SYSRST_CYC(SYSRST_CYC)) u_props (.*);
